/* File: common/pfm_map.svh */
// register offsets, field positions, reset values and select codes of the
// port 6 pin function mux; assumes inclusion by the package and design files
`ifndef PFM_MAP_SVH
`define PFM_MAP_SVH

// ============================================================================
// register indices (byte address is four times the index)
`define PFM_MAP01_IDX   24'hFF0054
`define PFM_MAP23_IDX   24'hFF0055
`define PFM_MAP45_IDX   24'hFF0056
`define PFM_ODRAIN_IDX  24'hFF0070
`define PFM_STATUS_IDX  24'hFF0071

// ============================================================================
// mapping register layout
`define PFM_MAP_RESET   8'h55
`define PFM_MAP_WMASK   8'h77
`define PFM_HI_LSB      4
`define PFM_LO_LSB      0
`define PFM_SEL_W       3

// ============================================================================
// select codes
`define PFM_SEL_NONE    3'h0
`define PFM_SEL_FIRST   3'h1
`define PFM_SEL_LAST    3'h6
`define PFM_SEL_TMRC    3'h3
`define PFM_SEL_TMRC_F  3'h2
`define PFM_SEL_SYNC    3'h4
`define PFM_SEL_D1FLT   3'h6

// ============================================================================
// status register layout
`define PFM_STAT_BLK_LSB 8

`endif

/* File: common/pfm_pkg.sv */
// types shared by the port 6 pin function mux
// assumes pfm_map.svh is on the include path
`include "pfm_map.svh"

package pfm_pkg;

	// ========================================================================
	// types
	typedef logic [`PFM_SEL_W-1:0] pfm_sel_t;

	typedef enum logic [1:0] {
		PFM_RESP_OKAY   = 2'h0,
		PFM_RESP_SLVERR = 2'h2
	} pfm_resp_t;

	typedef enum logic [5:0] {
		PFM_REG_NONE   = 6'h01,
		PFM_REG_MAP01  = 6'h02,
		PFM_REG_MAP23  = 6'h04,
		PFM_REG_MAP45  = 6'h08,
		PFM_REG_ODRAIN = 6'h10,
		PFM_REG_STATUS = 6'h20
	} pfm_reg_t;

endpackage

/* File: common/pfm_reg_if.sv */
// register access carrier between the bus slave and the mux core
// assumes both ends run on the same aclk
interface pfm_reg_if;
	logic        wr_en;
	logic [31:0] wr_addr;
	logic [7:0]  wr_data;
	logic        wr_lane0;
	logic        wr_ok;
	logic [31:0] rd_addr;
	logic [31:0] rd_data;
	logic        rd_ok;

	modport bus (
		output wr_en, wr_addr, wr_data, wr_lane0, rd_addr,
		input  wr_ok, rd_data, rd_ok
	);
	modport regs (
		input  wr_en, wr_addr, wr_data, wr_lane0, rd_addr,
		output wr_ok, rd_data, rd_ok
	);
endinterface

/* File: logic/pfm_pin_route.sv */
// one pin's function router: six peripheral slots, codes 1 to 6
// assumes the select is already cleaned of blocked and prohibited codes
`include "pfm_map.svh"
module pfm_pin_route
	import pfm_pkg::*;
#(
	parameter logic [5:0] IDLE = 6'h00
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire pfm_sel_t   sel,
	input  wire logic       od_en,
	input  wire logic [5:0] func_out,
	input  wire logic [5:0] func_oe,
	input  wire logic       pin_level,
	output logic            pin_out,
	output logic            pin_oe,
	output logic      [5:0] func_in
);

	logic       out_d;
	logic       oe_d;
	logic [5:0] in_d;
	logic [2:0] slot;

	// ========================================================================
	// routing
	always_comb begin
		slot  = sel - `PFM_SEL_FIRST;
		out_d = 1'b0;
		oe_d  = 1'b0;
		in_d  = IDLE;
		if (sel >= `PFM_SEL_FIRST && sel <= `PFM_SEL_LAST) begin
			out_d      = func_out[slot];
			oe_d       = func_oe[slot];
			in_d[slot] = pin_level;
		end
		if (od_en) begin
			oe_d  = oe_d & ~out_d;
			out_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out <= 1'b0;
			pin_oe  <= 1'b0;
			func_in <= IDLE;
		end else begin
			pin_out <= out_d;
			pin_oe  <= oe_d;
			func_in <= in_d;
		end
	end

endmodule

/* File: logic/pfm_axil_slave.sv */
// AXI4-Lite slave front end for the pin function mux registers
// assumes one write and one read under way at most; aclk domain only
module pfm_axil_slave
	import pfm_pkg::*;
(
	input  wire logic  aclk,
	input  wire logic  aresetn,
	input  wire logic [31:0] awaddr,
	input  wire logic  awvalid,
	output logic       awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic  wvalid,
	output logic       wready,
	output logic [1:0] bresp,
	output logic       bvalid,
	input  wire logic  bready,
	input  wire logic [31:0] araddr,
	input  wire logic  arvalid,
	output logic       arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic       rvalid,
	input  wire logic  rready,
	pfm_reg_if.bus     rif
);

	logic        aw_held_q, aw_held_d;
	logic [31:0] aw_addr_q, aw_addr_d;
	logic        w_held_q, w_held_d;
	logic [7:0]  w_data_q, w_data_d;
	logic        w_lane_q, w_lane_d;
	logic        bvalid_q, bvalid_d;
	pfm_resp_t   bresp_q, bresp_d;
	logic        rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	pfm_resp_t   rresp_q, rresp_d;

	// ========================================================================
	// handshakes
	assign awready = ~aw_held_q & ~bvalid_q;
	assign wready  = ~w_held_q & ~bvalid_q;
	assign arready = ~rvalid_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;

	assign rif.wr_en    = aw_held_q & w_held_q & ~bvalid_q;
	assign rif.wr_addr  = aw_addr_q;
	assign rif.wr_data  = w_data_q;
	assign rif.wr_lane0 = w_lane_q;
	assign rif.rd_addr  = araddr;

	// ========================================================================
	// write and read channels
	always_comb begin
		aw_held_d = aw_held_q;
		aw_addr_d = aw_addr_q;
		w_held_d  = w_held_q;
		w_data_d  = w_data_q;
		w_lane_d  = w_lane_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		if (awvalid && awready) begin
			aw_held_d = 1'b1;
			aw_addr_d = awaddr;
		end
		if (wvalid && wready) begin
			w_held_d = 1'b1;
			w_data_d = wdata[7:0];
			w_lane_d = wstrb[0];
		end
		if (rif.wr_en) begin
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = rif.wr_ok ? PFM_RESP_OKAY : PFM_RESP_SLVERR;
		end else if (bvalid_q && bready) begin
			bvalid_d = 1'b0;
		end
		if (arvalid && arready) begin
			rvalid_d = 1'b1;
			rdata_d  = rif.rd_data;
			rresp_d  = rif.rd_ok ? PFM_RESP_OKAY : PFM_RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= 32'h0000_0000;
			w_held_q  <= 1'b0;
			w_data_q  <= 8'h00;
			w_lane_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= PFM_RESP_OKAY;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= PFM_RESP_OKAY;
		end else begin
			aw_held_q <= aw_held_d;
			aw_addr_q <= aw_addr_d;
			w_held_q  <= w_held_d;
			w_data_q  <= w_data_d;
			w_lane_q  <= w_lane_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

endmodule

/* File: logic/pfm_port6_mux.sv */
// port 6 pin function mux, pins 0 to 5, with its mapping registers
// assumes peripherals on aclk; pin inputs arrive asynchronously
// slot k-1 of each pinN_func_* vector belongs to select code k
`include "pfm_map.svh"

module pfm_port6_mux
	import pfm_pkg::*;
#(
	parameter bit         HAS_TIMER_C   = 1'b1,
	parameter bit         HAS_D1_FAULT  = 1'b1,
	parameter logic [5:0] PIN0_IDLE     = 6'h00,
	parameter logic [5:0] PIN1_IDLE     = 6'h00,
	parameter logic [5:0] PIN2_IDLE     = 6'h00,
	parameter logic [5:0] PIN3_IDLE     = 6'h00,
	parameter logic [5:0] PIN4_IDLE     = 6'h00,
	parameter logic [5:0] PIN5_IDLE     = 6'h00
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [31:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic [5:0]  pin_in,
	output logic [5:0]       pin_out,
	output logic [5:0]       pin_oe,
	input  wire logic [5:0]  pin0_func_out,
	input  wire logic [5:0]  pin0_func_oe,
	output logic [5:0]       pin0_func_in,
	input  wire logic [5:0]  pin1_func_out,
	input  wire logic [5:0]  pin1_func_oe,
	output logic [5:0]       pin1_func_in,
	input  wire logic [5:0]  pin2_func_out,
	input  wire logic [5:0]  pin2_func_oe,
	output logic [5:0]       pin2_func_in,
	input  wire logic [5:0]  pin3_func_out,
	input  wire logic [5:0]  pin3_func_oe,
	output logic [5:0]       pin3_func_in,
	input  wire logic [5:0]  pin4_func_out,
	input  wire logic [5:0]  pin4_func_oe,
	output logic [5:0]       pin4_func_in,
	input  wire logic [5:0]  pin5_func_out,
	input  wire logic [5:0]  pin5_func_oe,
	output logic [5:0]       pin5_func_in
);

	// ========================================================================
	// declarations
	pfm_reg_if rif ();

	logic [7:0]  map_q [0:2];
	logic [7:0]  map_d [0:2];
	logic [5:0]  odrain_q, odrain_d;
	logic [5:0]  sync1_q, sync2_q;
	pfm_sel_t    sel_raw [0:5];
	pfm_sel_t    sel_eff [0:5];
	logic [5:0]  blocked;
	logic [5:0]  od_eff;
	logic [5:0]  fout [0:5];
	logic [5:0]  foe  [0:5];
	logic [5:0]  fin  [0:5];
	pfm_reg_t    wr_reg;
	pfm_reg_t    rd_reg;

	localparam logic [5:0] IDLE_ALL [0:5] = '{PIN0_IDLE, PIN1_IDLE, PIN2_IDLE,
		PIN3_IDLE, PIN4_IDLE, PIN5_IDLE};

	// ========================================================================
	// helper functions
	function automatic logic idx_hit(input logic [31:0] addr, input logic [23:0] idx);
		return addr[31:2] == {6'h00, idx};
	endfunction

	function automatic pfm_reg_t decode(input logic [31:0] addr);
		pfm_reg_t r;
		r = PFM_REG_NONE;
		if (idx_hit(addr, `PFM_MAP01_IDX))
			r = PFM_REG_MAP01;
		else if (idx_hit(addr, `PFM_MAP23_IDX))
			r = PFM_REG_MAP23;
		else if (idx_hit(addr, `PFM_MAP45_IDX))
			r = PFM_REG_MAP45;
		else if (idx_hit(addr, `PFM_ODRAIN_IDX))
			r = PFM_REG_ODRAIN;
		else if (idx_hit(addr, `PFM_STATUS_IDX))
			r = PFM_REG_STATUS;
		return r;
	endfunction

	// code allowed on this pin for this product variant
	function automatic logic code_ok(input int pin, input pfm_sel_t code);
		logic ok;
		ok = (code >= `PFM_SEL_FIRST) && (code <= `PFM_SEL_LAST);
		if (!HAS_TIMER_C && code == `PFM_SEL_TMRC && pin != 5)
			ok = 1'b0;
		if (!HAS_TIMER_C && code == `PFM_SEL_TMRC_F && pin == 3)
			ok = 1'b0;
		if (!HAS_D1_FAULT && code == `PFM_SEL_D1FLT && pin == 5)
			ok = 1'b0;
		return ok;
	endfunction

	// ========================================================================
	// bus front end
	pfm_axil_slave u_bus (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.rif     (rif.bus)
	);

	// ========================================================================
	// register writes
	assign wr_reg     = decode(rif.wr_addr);
	assign rif.wr_ok  = (wr_reg != PFM_REG_NONE) && (wr_reg != PFM_REG_STATUS);

	always_comb begin
		map_d    = map_q;
		odrain_d = odrain_q;
		if (rif.wr_en && rif.wr_lane0) begin
			unique case (wr_reg)
				PFM_REG_MAP01:  map_d[0] = rif.wr_data & `PFM_MAP_WMASK;
				PFM_REG_MAP23:  map_d[1] = rif.wr_data & `PFM_MAP_WMASK;
				PFM_REG_MAP45:  map_d[2] = rif.wr_data & `PFM_MAP_WMASK;
				PFM_REG_ODRAIN: odrain_d = rif.wr_data[5:0];
				PFM_REG_STATUS: odrain_d = odrain_q;
				PFM_REG_NONE:   odrain_d = odrain_q;
				default:        odrain_d = odrain_q;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			map_q[0] <= `PFM_MAP_RESET;
			map_q[1] <= `PFM_MAP_RESET;
			map_q[2] <= `PFM_MAP_RESET;
			odrain_q <= 6'h00;
		end else begin
			map_q    <= map_d;
			odrain_q <= odrain_d;
		end
	end

	// ========================================================================
	// register reads
	assign rd_reg    = decode(rif.rd_addr);
	assign rif.rd_ok = rd_reg != PFM_REG_NONE;

	always_comb begin
		rif.rd_data = 32'h0000_0000;
		unique case (rd_reg)
			PFM_REG_MAP01:  rif.rd_data[7:0] = map_q[0] & `PFM_MAP_WMASK;
			PFM_REG_MAP23:  rif.rd_data[7:0] = map_q[1] & `PFM_MAP_WMASK;
			PFM_REG_MAP45:  rif.rd_data[7:0] = map_q[2] & `PFM_MAP_WMASK;
			PFM_REG_ODRAIN: rif.rd_data[5:0] = odrain_q;
			PFM_REG_STATUS: rif.rd_data = {18'h00000, blocked, 2'h0, od_eff};
			PFM_REG_NONE:   rif.rd_data = 32'h0000_0000;
			default:        rif.rd_data = 32'h0000_0000;
		endcase
	end

	// ========================================================================
	// pin input synchronisers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= 6'h00;
			sync2_q <= 6'h00;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// ========================================================================
	// field extraction and effective selects
	assign sel_raw[0] = map_q[0][`PFM_LO_LSB +: `PFM_SEL_W];
	assign sel_raw[1] = map_q[0][`PFM_HI_LSB +: `PFM_SEL_W];
	assign sel_raw[2] = map_q[1][`PFM_LO_LSB +: `PFM_SEL_W];
	assign sel_raw[3] = map_q[1][`PFM_HI_LSB +: `PFM_SEL_W];
	assign sel_raw[4] = map_q[2][`PFM_LO_LSB +: `PFM_SEL_W];
	assign sel_raw[5] = map_q[2][`PFM_HI_LSB +: `PFM_SEL_W];

	always_comb begin
		for (int p = 0; p < 6; p++) begin
			blocked[p] = ~code_ok(p, sel_raw[p]);
			sel_eff[p] = blocked[p] ? `PFM_SEL_NONE : sel_raw[p];
			od_eff[p]  = odrain_q[p];
		end
		if (sel_eff[4] == `PFM_SEL_SYNC)
			od_eff[4] = 1'b0;
		if (sel_eff[5] == `PFM_SEL_SYNC)
			od_eff[5] = 1'b0;
	end

	// ========================================================================
	// peripheral slot gathering
	// pin0: irq0, serial ch1 clock, timer C a, G clock a, D0 a, E output
	// pin1: irq1, serial ch1 rx, timer C b, G clock b, D0 b, B trigger
	// pin2: irq2, serial ch1 tx, timer C c, G a, D0 c, B output
	// pin3: irq3, timer C fault, timer C d, G b, D0 d, A output
	// pin4: irq4, D0 fault, timer C clock, sync data, D0 a1, A io
	// pin5: irq5, serial ch2 clock, serial ch3 clock, sync clock, D0 b1, D1 fault
	assign fout[0] = pin0_func_out;
	assign fout[1] = pin1_func_out;
	assign fout[2] = pin2_func_out;
	assign fout[3] = pin3_func_out;
	assign fout[4] = pin4_func_out;
	assign fout[5] = pin5_func_out;
	assign foe[0]  = pin0_func_oe;
	assign foe[1]  = pin1_func_oe;
	assign foe[2]  = pin2_func_oe;
	assign foe[3]  = pin3_func_oe;
	assign foe[4]  = pin4_func_oe;
	assign foe[5]  = pin5_func_oe;
	assign pin0_func_in = fin[0];
	assign pin1_func_in = fin[1];
	assign pin2_func_in = fin[2];
	assign pin3_func_in = fin[3];
	assign pin4_func_in = fin[4];
	assign pin5_func_in = fin[5];

	// ========================================================================
	// per-pin routers
	for (genvar g = 0; g < 6; g++) begin : g_pin
		pfm_pin_route #(
			.IDLE (IDLE_ALL[g])
		) u_route (
			.aclk      (aclk),
			.aresetn   (aresetn),
			.sel       (sel_eff[g]),
			.od_en     (od_eff[g]),
			.func_out  (fout[g]),
			.func_oe   (foe[g]),
			.pin_level (sync2_q[g]),
			.pin_out   (pin_out[g]),
			.pin_oe    (pin_oe[g]),
			.func_in   (fin[g])
		);
	end

endmodule

/* File: testbench/pfm_port6_monitor.sv */
// checker for the port 6 pin function mux top ports
// assumes bind onto pfm_port6_mux; idle input levels are zero
module pfm_port6_monitor
	import pfm_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        awvalid,
	input  wire logic        awready,
	input  wire logic        wvalid,
	input  wire logic        wready,
	input  wire logic        bvalid,
	input  wire logic        bready,
	input  wire logic [31:0] araddr,
	input  wire logic        arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	input  wire logic        rready,
	input  wire logic [5:0]  pin_oe,
	input  wire logic [5:0]  pin0_func_oe,
	input  wire logic [5:0]  pin5_func_oe,
	input  wire logic [5:0]  pin4_func_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// ========================================================================
	// read address capture
	localparam logic [31:0] MAP_FIRST = 32'h03FC0150;
	localparam logic [31:0] MAP_LAST  = 32'h03FC0158;
	logic [31:0] rd_addr_d;
	logic [31:0] rd_addr_q;
	always_comb begin
		rd_addr_d = (arvalid && arready) ? araddr : rd_addr_q;
	end
	always_ff @(posedge aclk) begin
		rd_addr_q <= aresetn ? rd_addr_d : 32'h0;
	end

	// ========================================================================
	// properties
	default clocking mon_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	rd_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read not answered next cycle");
	rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read answer dropped early");
	rd_block_a: assert property (rvalid |-> !arready)
		else $error("read taken while answer pending");
	wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write not answered in two cycles");
	wr_hold_a: assert property (bvalid && !bready |=> bvalid ##0 (!awready && !wready))
		else $error("write answer dropped early");
	map_rsv_a: assert property (
		rvalid && rresp == PFM_RESP_OKAY && rd_addr_q >= MAP_FIRST && rd_addr_q <= MAP_LAST
		|-> rdata[31:8] == 24'h0 && !rdata[7] && !rdata[3])
		else $error("mapping read shows reserved bits");
	oe_pin0_a: assert property (pin_oe[0] |-> |$past(pin0_func_oe))
		else $error("pin 0 driven without a peripheral enable");
	oe_pin5_a: assert property (pin_oe[5] |-> |$past(pin5_func_oe))
		else $error("pin 5 driven without a peripheral enable");
	fin_onehot_a: assert property ($onehot0(pin4_func_in))
		else $error("pin 4 level reaches more than one peripheral");
endmodule

bind pfm_port6_mux pfm_port6_monitor mon_u (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
	.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rresp(rresp), .rvalid(rvalid), .rready(rready), .pin_oe(pin_oe),
	.pin0_func_oe(pin0_func_oe), .pin5_func_oe(pin5_func_oe),
	.pin4_func_in(pin4_func_in)
);

/* File: testbench/pfm_periph_model.sv */
// peripherals and pin wires around the port 6 mux
// assumes one drive pattern shared by all six pins
module pfm_periph_model (
	input  wire logic [5:0] slot_out,
	input  wire logic [5:0] slot_oe,
	input  wire logic [5:0] ext_level,
	input  wire logic [5:0] pin_out,
	input  wire logic [5:0] pin_oe,
	output logic      [5:0] func_out,
	output logic      [5:0] func_oe,
	output logic      [5:0] pin_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// ========================================================================
	// peripheral drive and wire level
	assign func_out = slot_out;
	assign func_oe  = slot_oe;
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
		end
	end
endmodule

/* File: testbench/port6_function_mapping_mux_tb.sv */
// self-checking bench for the port 6 pin function mux
// assumes the monitor bind and the peripheral model are compiled
module port6_function_mapping_mux_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import pfm_pkg::*;
	// ========================================================================
	// signals
	localparam logic [31:0] MAP_ADDR  = 32'h03FC0150;
	localparam logic [31:0] ODR_ADDR  = 32'h03FC01C0;
	localparam logic [31:0] STAT_ADDR = 32'h03FC01C4;
	logic        aclk = 0;
	logic        aresetn = 0;
	logic [31:0] awaddr = 0;
	logic [31:0] wdata = 0;
	logic [31:0] araddr = 0;
	logic [3:0]  wstrb = 0;
	logic        awvalid = 0;
	logic        wvalid = 0;
	logic        bready = 0;
	logic        arvalid = 0;
	logic        rready = 0;
	logic [5:0]  slot_out = 6'h10;
	logic [5:0]  slot_oe = 6'h10;
	logic [5:0]  ext_level = 6'h3F;
	logic [5:0]  s;
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [5:0]  pin_in, pin_out, pin_oe, func_out, func_oe;
	wire  [5:0]  fin [0:5];
	wire  [5:0]  fin_v [0:5];
	wire  [5:0]  pin_oe_v;
	logic        blk;
	int          miscompares = 0;
	int          tests_run = 0;

	always #2.5 aclk = ~aclk;

	pfm_periph_model model_u (.slot_out(slot_out), .slot_oe(slot_oe), .ext_level(ext_level),
		.pin_out(pin_out), .pin_oe(pin_oe), .func_out(func_out), .func_oe(func_oe),
		.pin_in(pin_in));

	pfm_port6_mux dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin0_func_out(func_out), .pin0_func_oe(func_oe), .pin0_func_in(fin[0]),
		.pin1_func_out(func_out), .pin1_func_oe(func_oe), .pin1_func_in(fin[1]),
		.pin2_func_out(func_out), .pin2_func_oe(func_oe), .pin2_func_in(fin[2]),
		.pin3_func_out(func_out), .pin3_func_oe(func_oe), .pin3_func_in(fin[3]),
		.pin4_func_out(func_out), .pin4_func_oe(func_oe), .pin4_func_in(fin[4]),
		.pin5_func_out(func_out), .pin5_func_oe(func_oe), .pin5_func_in(fin[5]));

	// variant without timer C and without the D1 fault input
	pfm_port6_mux #(.HAS_TIMER_C(1'b0), .HAS_D1_FAULT(1'b0)) dut_var_u (.aclk(aclk),
		.aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(), .bresp(), .bvalid(), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(), .rdata(), .rresp(), .rvalid(),
		.rready(rready), .pin_in(ext_level), .pin_out(), .pin_oe(pin_oe_v),
		.pin0_func_out(func_out), .pin0_func_oe(func_oe), .pin0_func_in(fin_v[0]),
		.pin1_func_out(func_out), .pin1_func_oe(func_oe), .pin1_func_in(fin_v[1]),
		.pin2_func_out(func_out), .pin2_func_oe(func_oe), .pin2_func_in(fin_v[2]),
		.pin3_func_out(func_out), .pin3_func_oe(func_oe), .pin3_func_in(fin_v[3]),
		.pin4_func_out(func_out), .pin4_func_oe(func_oe), .pin4_func_in(fin_v[4]),
		.pin5_func_out(func_out), .pin5_func_oe(func_oe), .pin5_func_in(fin_v[5]));

	// ========================================================================
	// compare, bus and closing tasks
	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic [5:0] got, input logic [5:0] exp);
		chk_data({26'h0, got}, {26'h0, exp});
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_done;
		logic w_done;
		aw_done = 0;
		w_done = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1;
		wvalid <= 1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) begin
				awvalid <= 0;
				aw_done = 1;
			end
			if (wvalid && wready === 1'b1) begin
				wvalid <= 0;
				w_done = 1;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		bready <= 1;
		@(posedge aclk);
		bready <= 0;
		chk_data({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1;
		@(posedge aclk);
		rready <= 0;
		chk_data(rdata, exp);
		chk_data({30'h0, rresp}, {30'h0, er});
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		wrap_up();
	end

	// ========================================================================
	// tests
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		repeat (6) @(posedge aclk);
		for (int r = 0; r < 3; r++) rd(MAP_ADDR + 4 * r, 32'h55, PFM_RESP_OKAY);
		chk_pin(pin_oe, 6'h3F);
		chk_pin(pin_out, 6'h3F);
		for (int p = 0; p < 6; p++) chk_pin(fin[p], 6'h10);
		$display("test reset_values done");
		wr(MAP_ADDR, 32'hAE, PFM_RESP_OKAY);
		rd(MAP_ADDR, 32'h26, PFM_RESP_OKAY);
		$display("test reserved_bits done");
		for (int r = 0; r < 3; r++) begin
			for (int k = 1; k < 7; k++) begin
				s = (k >= 1 && k <= 6) ? 6'h01 << (k - 1) : 6'h00;
				slot_oe <= (s != 0) ? s : 6'h3F;
				slot_out <= (s != 0) ? s : 6'h3F;
				wr(MAP_ADDR + 4 * r, {25'h0, k[2:0], 1'b0, k[2:0]}, PFM_RESP_OKAY);
				rd(MAP_ADDR + 4 * r, {25'h0, k[2:0], 1'b0, k[2:0]}, PFM_RESP_OKAY);
				repeat (5) @(posedge aclk);
				chk_pin({4'h0, pin_oe[2 * r +: 2]}, (s != 0) ? 6'h03 : 6'h00);
				chk_pin(fin[2 * r], s);
				chk_pin(fin[2 * r + 1], s);
				for (int p = 2 * r; p < 2 * r + 2; p++) begin
					blk = (k == 3 && p != 5) || (k == 2 && p == 3) || (k == 6 && p == 5);
					chk_pin(fin_v[p], blk ? 6'h00 : s);
					chk_pin({5'h0, pin_oe_v[p]}, {5'h0, !blk});
				end
			end
		end
		$display("test select_codes done");
		slot_oe <= 6'h08;
		slot_out <= 6'h08;
		wr(ODR_ADDR, 32'h3F, PFM_RESP_OKAY);
		wr(MAP_ADDR, 32'h44, PFM_RESP_OKAY);
		wr(MAP_ADDR + 8, 32'h44, PFM_RESP_OKAY);
		repeat (5) @(posedge aclk);
		chk_pin(pin_oe & 6'h33, 6'h30);
		chk_pin(pin_out & 6'h33, 6'h30);
		rd(STAT_ADDR, 32'h0F, PFM_RESP_OKAY);
		wr(ODR_ADDR, 32'h0, PFM_RESP_OKAY);
		$display("test sync_serial_drain done");
		rd(32'h0, 32'h0, PFM_RESP_SLVERR);
		wr(32'h0, 32'h0, PFM_RESP_SLVERR);
		wr(STAT_ADDR, 32'h0, PFM_RESP_SLVERR);
		rd(MAP_ADDR + 8, 32'h44, PFM_RESP_OKAY);
		$display("test refused_access done");
		wrap_up();
	end
endmodule
